// File: logic/irx_pkg.sv
// Package for the isochronous dual-packet receive status block.
// Assumes one clock domain; all event inputs are single-cycle strobes.
// Behaviour
// - Empty FIFO, OUT token with receive disabled: set void, fill stays 00, no NAK.
// - OUT token timing out waiting for data changes nothing and loads nothing.
// - Good packet into empty FIFO: advance write marker, fill 01, ack set, error/void clear.
// - CRC or stuff error into empty FIFO: keep data, fill 01, error set, ack clear.
// - FIFO error during reception: set overrun and error, clear ack.
// - OUT token with existing FIFO error is void; fill, error, overrun kept.
// - Read of empty FIFO sets underrun, fill stays 00.
// - Isochronous receive never returns a handshake; no NAK ever.
// - Firmware changes fill and flags at once; USB changes to fill and overrun apply at SOF.
// - Underrun is set immediately on the offending read.
// - Overrun from reception becomes visible at the following SOF.
// - Read-complete decrements fill at once; good reception increments at next SOF.
// - Error, ack and void update at the end of the causing transaction.
// - SOF commits pending updates and raises only the SOF interrupt.
// - One packet held: good or FIFO-error packet moves fill to 11.
// - One packet held, CRC error: fill 11, error set, write pointer reversed.
// - Read-complete: one packet held goes to 00, 11 goes to one held.
// - OUT token with both slots full sets void and keeps fill.
// - Underrunning read does not change fill until read-complete.
// - Overrun and underrun are sticky; only firmware clears them.
// - Behaviour applies with single-packet mode control at 0.
package irx_pkg;
   localparam int IRX_DATA_W = 8;
   localparam int IRX_FIFO_DEPTH = 8;
   localparam logic [1:0] IRX_FILL_EMPTY = 2'h0;
   localparam logic [1:0] IRX_FILL_ONE_A = 2'h1;
   localparam logic [1:0] IRX_FILL_ONE_B = 2'h2;
   localparam logic [1:0] IRX_FILL_FULL = 2'h3;
   localparam logic IRX_FLAG_RST = 1'b0;
   // Transaction outcome, one-hot
   typedef enum logic [4:0] {
      IRX_OUT_GOOD = 5'h01,
      IRX_OUT_CRC = 5'h02,
      IRX_OUT_FIFOERR = 5'h04,
      IRX_OUT_TIMEOUT = 5'h08,
      IRX_OUT_NONE = 5'h10
   } irx_outcome_t;
endpackage

// File: logic/irx_fifo_if.sv
// Handshake bundle between the status logic and its data FIFO.
// Assumes both ends share the block clock.
`timescale 1ns/100ps
interface irx_fifo_if;
   import irx_pkg::*;
   logic inValid;
   logic inReady;
   logic [IRX_DATA_W-1:0] inData;
   logic outValid;
   logic outReady;
   logic [IRX_DATA_W-1:0] outData;
   modport src (output inValid, output inData, input inReady,
      input outValid, input outData, output outReady);
   modport buf_side (input inValid, input inData, output inReady,
      output outValid, output outData, input outReady);
endinterface

// File: logic/irx_fifo.sv
// Small synchronous FIFO holding received bytes on their way to the CPU.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/100ps
module irx_fifo
   import irx_pkg::*;
#(
   parameter int WIDTH = IRX_DATA_W,
   parameter int DEPTH = IRX_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   irx_fifo_if.buf_side port
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   logic [WIDTH-1:0] readData;
   wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   wire empty = (wrPtr == rdPtr);
   wire doWrite = port.inValid && !full;
   wire doRead = port.outReady && !empty;
   assign port.inReady = !full;
   assign port.outValid = !empty;
   assign port.outData = readData;
   // Storage and pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (doWrite) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (doRead) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr[AW-1:0]] <= port.inData;
      end
   end
   // Registered read data tracks the head word
   always_ff @(posedge clk) begin
      if (rst) begin
         readData <= '0;
      end else begin
         readData <= mem[(doRead ? rdPtr[AW-1:0] + 1'b1 : rdPtr[AW-1:0])];
      end
   end
endmodule

// File: logic/irx_status.sv
// Isochronous receive status logic, dual-packet mode, with its data FIFO.
// Assumes SIE strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/100ps
module irx_status
   import irx_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rx_input_enable,
   input wire logic rx_endpoint_enable,
   input wire logic rx_single_packet_mode,
   input wire logic outToken,
   input wire logic outDone,
   input wire logic outGood,
   input wire logic outCrcErr,
   input wire logic outFifoErr,
   input wire logic outTimeout,
   input wire logic sofStrobe,
   input wire logic byteValid,
   input wire logic [IRX_DATA_W-1:0] byteData,
   output logic byteReady,
   input wire logic cpuRead,
   output logic [IRX_DATA_W-1:0] cpuData,
   output logic cpuDataValid,
   input wire logic rx_read_complete,
   input wire logic clearOverrun,
   input wire logic clearUnderrun,
   output logic [1:0] rx_fill_state,
   output logic rx_error_flag,
   output logic rx_acknowledge_flag,
   output logic rx_void_flag,
   output logic rx_overrun_flag,
   output logic rx_underrun_flag,
   output logic sofIrq,
   output logic nakSend,
   output logic writeMarkAdvance,
   output logic writePtrReverse
);
   irx_fifo_if fifoBus ();
   irx_fifo #(.WIDTH(IRX_DATA_W), .DEPTH(IRX_FIFO_DEPTH)) dataFifo (
      .clk(clk),
      .rst(rst),
      .port(fifoBus.buf_side)
   );

   logic pendInc;
   logic pendOvf;
   logic outPending;
   // Shadow of pending USB effects, committed at SOF
   wire active = rx_endpoint_enable && !rx_single_packet_mode;
   wire fifoErrNow = rx_overrun_flag || pendOvf;
   wire oneHeld = (rx_fill_state == IRX_FILL_ONE_A) || (rx_fill_state == IRX_FILL_ONE_B);
   wire slotsUsed = rx_fill_state == IRX_FILL_FULL || pendInc;
   // Disabled, full, or faulted FIFO voids the token
   wire voidToken = active && outToken && (!rx_input_enable || fifoErrNow
      || rx_fill_state == IRX_FILL_FULL || (oneHeld && pendInc));
   wire endGood = active && outDone && outPending && outGood;
   wire endCrc = active && outDone && outPending && outCrcErr;
   wire endFifo = active && outDone && outPending && outFifoErr;
   wire endTmo = active && outDone && outPending && outTimeout;
   wire loadsSlot = endGood || endCrc || endFifo;
   wire crcDropped = endCrc && oneHeld;
   wire rcStep = rx_read_complete && rx_fill_state != IRX_FILL_EMPTY;
   wire emptyRead = cpuRead && !fifoBus.outValid;
   // A committed increment lands on the fill after any same-cycle decrement
   wire [1:0] afterDec = rcStep ? (rx_fill_state == IRX_FILL_FULL ? IRX_FILL_ONE_A
      : IRX_FILL_EMPTY) : rx_fill_state;
   wire [1:0] afterInc = (afterDec == IRX_FILL_EMPTY) ? IRX_FILL_ONE_A : IRX_FILL_FULL;
   wire [1:0] next_fill = (sofStrobe && pendInc) ? afterInc : afterDec;

   assign nakSend = 1'b0;
   assign sofIrq = sofStrobe && active;
   assign fifoBus.inValid = byteValid && outPending && rx_input_enable;
   assign fifoBus.inData = byteData;
   assign byteReady = fifoBus.inReady;
   assign fifoBus.outReady = cpuRead;
   assign cpuData = fifoBus.outData;
   assign cpuDataValid = fifoBus.outValid;

   // Transaction tracking: an accepted token opens a data phase
   always_ff @(posedge clk) begin
      if (rst) begin
         outPending <= 1'b0;
      end else if (outToken && active) begin
         outPending <= !voidToken;
      end else if (outDone) begin
         outPending <= 1'b0;
      end
   end

   // Pending increment and overrun, visible only after SOF
   always_ff @(posedge clk) begin
      if (rst) begin
         pendInc <= 1'b0;
         pendOvf <= 1'b0;
      end else begin
         if (sofStrobe) begin
            pendInc <= 1'b0;
         end else if (loadsSlot && !slotsUsed) begin
            pendInc <= 1'b1;
         end
         if (sofStrobe) begin
            pendOvf <= endFifo;
         end else if (endFifo) begin
            pendOvf <= 1'b1;
         end
      end
   end

   // Fill state: firmware steps apply now, USB steps at SOF
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_fill_state <= IRX_FILL_EMPTY;
      end else begin
         rx_fill_state <= next_fill;
      end
   end

   // Transaction flags settle at transaction end
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_error_flag <= IRX_FLAG_RST;
         rx_acknowledge_flag <= IRX_FLAG_RST;
         rx_void_flag <= IRX_FLAG_RST;
      end else if (voidToken) begin
         rx_void_flag <= 1'b1;
      end else if (endGood) begin
         rx_error_flag <= 1'b0;
         rx_acknowledge_flag <= 1'b1;
         rx_void_flag <= 1'b0;
      end else if (endCrc || endFifo) begin
         rx_error_flag <= 1'b1;
         rx_acknowledge_flag <= 1'b0;
         rx_void_flag <= 1'b0;
      end
   end

   // Sticky overrun and underrun; a set wins over a clear
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_overrun_flag <= IRX_FLAG_RST;
         rx_underrun_flag <= IRX_FLAG_RST;
      end else begin
         if (sofStrobe && (pendOvf || endFifo)) begin
            rx_overrun_flag <= 1'b1;
         end else if (clearOverrun) begin
            rx_overrun_flag <= 1'b0;
         end
         if (emptyRead) begin
            rx_underrun_flag <= 1'b1;
         end else if (clearUnderrun) begin
            rx_underrun_flag <= 1'b0;
         end
      end
   end

   // Write marker pulses for the FIFO pointer logic
   always_ff @(posedge clk) begin
      if (rst) begin
         writeMarkAdvance <= 1'b0;
         writePtrReverse <= 1'b0;
      end else begin
         writeMarkAdvance <= endGood;
         writePtrReverse <= crcDropped;
      end
   end

   // Checks
   a_no_nak: assert property (@(posedge clk) disable iff (rst) !nakSend)
      else $error("NAK driven on isochronous receive");
   a_underrun_now: assert property (@(posedge clk) disable iff (rst)
      emptyRead |=> rx_underrun_flag)
      else $error("underrun not set on empty read");
   a_fill_waits_sof: assert property (@(posedge clk) disable iff (rst)
      (!sofStrobe && !rx_read_complete) |=> $stable(rx_fill_state))
      else $error("fill changed without SOF or read-complete");
   a_rc_one_empty: assert property (@(posedge clk) disable iff (rst)
      (rx_read_complete && oneHeld && !sofStrobe) |=> rx_fill_state == IRX_FILL_EMPTY)
      else $error("read-complete did not empty one held");
   a_void_empty: assert property (@(posedge clk) disable iff (rst)
      (voidToken && rx_fill_state == IRX_FILL_EMPTY && !sofStrobe)
      |=> rx_void_flag && rx_fill_state == IRX_FILL_EMPTY)
      else $error("void token mishandled");
   a_good_ack: assert property (@(posedge clk) disable iff (rst)
      endGood |=> rx_acknowledge_flag && !rx_error_flag && !rx_void_flag)
      else $error("good packet flags wrong");
   a_crc_error: assert property (@(posedge clk) disable iff (rst)
      endCrc |=> rx_error_flag && !rx_acknowledge_flag)
      else $error("CRC packet flags wrong");
   a_ovf_at_sof: assert property (@(posedge clk) disable iff (rst)
      (endFifo && !sofStrobe) |=> !$rose(rx_overrun_flag))
      else $error("overrun visible before SOF");
   a_ovf_sticky: assert property (@(posedge clk) disable iff (rst)
      (rx_overrun_flag && !clearOverrun) |=> rx_overrun_flag)
      else $error("overrun cleared without firmware");
   a_timeout_quiet: assert property (@(posedge clk) disable iff (rst)
      (endTmo && !sofStrobe && !rx_read_complete && !emptyRead)
      |=> $stable(rx_fill_state) && $stable(rx_error_flag) && $stable(rx_void_flag))
      else $error("timeout altered status");
endmodule

// File: dv/irx_sie_model.sv
// Stand-in for the serial interface engine: OUT token, bytes, outcome.
// Assumes the bench calls send() while clk runs; moves at falling edges.
`timescale 1ns/100ps
module irx_sie_model
   import irx_pkg::*;
(
   input wire logic clk,
   input wire logic byteReady,
   output logic outToken,
   output logic outDone,
   output logic [3:0] outcome,
   output logic byteValid,
   output logic [IRX_DATA_W-1:0] byteData
);
   // Idle bus at time zero
   initial begin
      outToken = 1'b0;
      outDone = 1'b0;
      outcome = 4'h0;
      byteValid = 1'b0;
      byteData = 8'h5a;
   end

   // One transaction; NONE sends a bare token that the block should void
   task automatic send(input irx_outcome_t kind, input int n, input logic [7:0] base);
      @(negedge clk);
      outToken = 1'b1;
      @(negedge clk);
      outToken = 1'b0;
      for (int i = 0; i < n; i++) begin
         byteValid = 1'b1;
         byteData = base + i[7:0];
         while (!byteReady) @(negedge clk); // Byte held until the FIFO takes it
         @(negedge clk);
      end
      byteValid = 1'b0;
      byteData = ~byteData; // Released lines show no stale byte
      if (kind != IRX_OUT_NONE) begin
         outDone = 1'b1;
         outcome = kind[3:0]; // Exactly one outcome with the end strobe
         @(negedge clk);
      end
      outDone = 1'b0;
      outcome = 4'h0;
   endtask
endmodule

// File: dv/irx_status_tb.sv
// Self-checking bench for the isochronous receive status block.
// Assumes the engine model above; firmware strobes come from this bench.
`timescale 1ns/100ps
module irx_status_tb;
   import irx_pkg::*;
   logic clk, rst, inEn, spm, outToken, outDone, byteValid, byteReady, cpuDataValid;
   logic [4:0] fw; // {sof, clearUnder, clearOver, readComplete, cpuRead}
   logic [3:0] outcome;
   logic [IRX_DATA_W-1:0] byteData, cpuData;
   logic [1:0] fill;
   logic err, ack, voidFlag, ovf, urf, sofIrq, nak, wma, wpr;
   int n_mismatch = 0;
   int checks_done = 0;

   // Endpoint enabled; single-packet mode driven so its gating is exercised
   irx_status i_irx_status (.clk(clk), .rst(rst), .rx_input_enable(inEn),
      .rx_endpoint_enable(1'b1), .rx_single_packet_mode(spm), .outToken(outToken),
      .outDone(outDone), .outGood(outcome[0]), .outCrcErr(outcome[1]),
      .outFifoErr(outcome[2]), .outTimeout(outcome[3]), .sofStrobe(fw[4]),
      .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
      .cpuRead(fw[0]), .cpuData(cpuData), .cpuDataValid(cpuDataValid),
      .rx_read_complete(fw[1]), .clearOverrun(fw[2]), .clearUnderrun(fw[3]),
      .rx_fill_state(fill), .rx_error_flag(err), .rx_acknowledge_flag(ack),
      .rx_void_flag(voidFlag), .rx_overrun_flag(ovf), .rx_underrun_flag(urf),
      .sofIrq(sofIrq), .nakSend(nak), .writeMarkAdvance(wma), .writePtrReverse(wpr));
   irx_sie_model i_irx_sie_model (.clk(clk), .byteReady(byteReady), .outToken(outToken),
      .outDone(outDone), .outcome(outcome), .byteValid(byteValid), .byteData(byteData));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Status packed as {fill, err, ack, void, overrun, underrun}
   task automatic st(input logic [6:0] exp);
      chk({1'b0, fill, err, ack, voidFlag, ovf, urf}, {1'b0, exp});
   endtask

   // One-cycle firmware or frame strobe; interrupt seen while SOF is high
   task automatic fire(input int b);
      @(negedge clk);
      fw[b] = 1'b1;
      #1;
      if (b == 4) chk(sofIrq, 1'b1);
      @(negedge clk);
      fw = 5'h0;
   endtask

   task automatic doReset;
      @(negedge clk);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      st(7'h00);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard, far beyond the roughly 100 cycles the sequence needs
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      results;
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      inEn = 1'b0;
      spm = 1'b0;
      fw = 5'h0;
      doReset;
      i_irx_sie_model.send(IRX_OUT_NONE, 0, 8'h00);
      st(7'b0000100);
      inEn = 1'b1;
      i_irx_sie_model.send(IRX_OUT_TIMEOUT, 0, 8'h00);
      st(7'b0000100);
      i_irx_sie_model.send(IRX_OUT_GOOD, 4, 8'h10);
      st(7'b0001000);
      chk(wma, 1'b1);
      fire(4);
      st(7'b0101000);
      i_irx_sie_model.send(IRX_OUT_GOOD, 4, 8'h20);
      chk(byteReady, 1'b0); // Eight words held, FIFO refuses more
      st(7'b0101000);
      fire(4);
      st(7'b1101000);
      i_irx_sie_model.send(IRX_OUT_NONE, 0, 8'h00);
      st(7'b1101100);
      // Drain in arrival order, then one read too many
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         chk(cpuDataValid, 1'b1);
         chk(cpuData, (i < 4) ? 8'h10 + i[7:0] : 8'h1c + i[7:0]);
         fire(0);
      end
      chk(cpuDataValid, 1'b0);
      fire(0);
      st(7'b1101101);
      // Both slots released before any further frame
      fire(1);
      st(7'b0101101);
      fire(1);
      st(7'b0001101);
      fire(0);
      st(7'b0001101);
      fire(3);
      st(7'b0001100);
      i_irx_sie_model.send(IRX_OUT_CRC, 2, 8'h30);
      st(7'b0010000);
      fire(4);
      st(7'b0110000);
      i_irx_sie_model.send(IRX_OUT_CRC, 2, 8'h40);
      chk(wpr, 1'b1);
      chk(err, 1'b1);
      doReset;
      i_irx_sie_model.send(IRX_OUT_FIFOERR, 2, 8'h50);
      st(7'b0010000);
      fire(4);
      st(7'b0110010);
      i_irx_sie_model.send(IRX_OUT_NONE, 0, 8'h00);
      st(7'b0110110);
      fire(2);
      st(7'b0110100);
      chk(nak, 1'b0);
      // Single-packet mode: dual-packet status must ignore the token
      spm = 1'b1;
      i_irx_sie_model.send(IRX_OUT_NONE, 0, 8'h00);
      st(7'b0110100);
      results;
   end
endmodule
